// ---- hdl/ddrx_pkg.sv ----
// Constants shared by the DDR 1:8 receiver and its word buffer.
// Assumes a single system clock; all pin inputs are asynchronous to it.
package ddrx_pkg;
    localparam int unsigned LANES_PER_GROUP = 4;
    localparam int unsigned BITS_PER_WORD   = 8;
    localparam int unsigned FIFO_DEPTH      = 32;
    localparam int unsigned OFFSET_W        = 3;
    localparam logic [7:0]  FRAME_PATTERN   = 8'h0F;
    localparam logic [1:0]  LAST_PAIR       = 2'h3;
    localparam logic [1:0]  PAIR_CNT_RST    = 2'h0;
    localparam logic [2:0]  OFFSET_RST      = 3'h0;
    localparam logic [7:0]  WORD_RST        = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b11
    } ddrx_state_type;
endpackage

// ---- hdl/ddrx_fifo.sv ----
// Word buffer between the deserializer and system logic, with fill flags.
// Assumes one clock; pointers still cross as Gray codes so a split clock is a small change.
`timescale 1ns/1ps
module ddrx_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = ddrx_pkg::FIFO_DEPTH,
    localparam int unsigned AW   = $clog2(DEPTH)
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data,
    output logic                  o_quarter,
    output logic                  o_half,
    output logic                  o_three_quarter
);
    localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
    localparam logic [AW:0] Q1_LVL   = (AW+1)'(DEPTH / 4);
    localparam logic [AW:0] Q2_LVL   = (AW+1)'(DEPTH / 2);
    localparam logic [AW:0] Q3_LVL   = (AW+1)'((3 * DEPTH) / 4);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rgray_q;
    logic [AW:0]      wg_s1_q;
    logic [AW:0]      wg_s2_q;
    logic [AW:0]      rg_s1_q;
    logic [AW:0]      rg_s2_q;
    logic [AW:0]      wbin_d;
    logic [AW:0]      rbin_d;
    logic [AW:0]      wr_level;
    logic             wr_fire;
    logic             rd_fire;

    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Flags come from the synchronised read pointer, so they may read high a little long
    assign wr_level        = wbin_q - gray2bin(rg_s2_q);
    assign o_wr_ready      = (wr_level != FULL_LVL);
    assign o_rd_valid      = (rbin_q != gray2bin(wg_s2_q));
    assign o_rd_data       = mem[rbin_q[AW-1:0]];
    assign o_quarter       = (wr_level >= Q1_LVL);
    assign o_half          = (wr_level >= Q2_LVL);
    assign o_three_quarter = (wr_level >= Q3_LVL);
    assign wr_fire         = i_wr_valid & o_wr_ready;
    assign rd_fire         = o_rd_valid & i_rd_ready;
    assign wbin_d          = wbin_q + (AW+1)'(1);
    assign rbin_d          = rbin_q + (AW+1)'(1);

    always_ff @(posedge i_clk) begin
        if (wr_fire) begin
            mem[wbin_q[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end else if (wr_fire) begin
            wbin_q  <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rbin_q  <= '0;
            rgray_q <= '0;
        end else if (rd_fire) begin
            rbin_q  <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wg_s1_q <= '0;
            wg_s2_q <= '0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    gray_step_a: assert property ($onehot0(wgray_q ^ $past(wgray_q)))
        else $error("write gray pointer moved by more than one bit");
    flag_order_a: assert property ((o_three_quarter |-> o_half) and (o_half |-> o_quarter))
        else $error("fill flags out of order");
    full_hold_a: assert property (i_wr_valid && !o_wr_ready |=> wbin_q == $past(wbin_q))
        else $error("write taken while full");
    fill_three_c: cover property (o_three_quarter ##1 !o_three_quarter);
endmodule

// ---- hdl/ddrx_rx_top.sv ----
// Source-synchronous DDR receiver, 1:8 per lane, words into per-group buffers.
// Assumes forwarded clock, frame and data arrive on pins, asynchronous to i_clk,
// and that i_clk runs fast enough to see every half period of the forwarded clock.
`timescale 1ns/1ps
module ddrx_rx_top #(
    parameter int unsigned  LANES  = 4,
    parameter int unsigned  DEPTH  = ddrx_pkg::FIFO_DEPTH,
    localparam int unsigned GROUPS = LANES / ddrx_pkg::LANES_PER_GROUP
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_b,
    input  wire logic                          i_forwarded_rx_clock,
    input  wire logic                          i_frame,
    input  wire logic [LANES-1:0]              i_data,
    input  wire logic                          i_frame_en,
    input  wire logic [ddrx_pkg::OFFSET_W-1:0] i_digital_phase_offset,
    input  wire logic                          i_rd_ready,
    output logic [8*LANES-1:0]                 o_rd_data,
    output logic                               o_rd_valid,
    output logic [GROUPS-1:0]                  o_quarter,
    output logic [GROUPS-1:0]                  o_half,
    output logic [GROUPS-1:0]                  o_three_quarter,
    output logic                               o_overrun,
    output logic                               o_phase_locked
);
    localparam int unsigned NIN  = LANES + 1;
    localparam int unsigned ODEP = 2 ** ddrx_pkg::OFFSET_W;
    localparam int unsigned GW   = 8 * ddrx_pkg::LANES_PER_GROUP;

    ddrx_pkg::ddrx_state_type state_q;

    logic [NIN:0]                  pin_in;
    logic [NIN:0]                  s1_q;
    logic [NIN:0]                  s2_q;
    logic [NIN:0]                  s3_q;
    logic [NIN:0]                  lvl_q;
    logic                          clk_prev_q;
    logic                          rise_raw;
    logic                          fall_raw;
    logic [ODEP-2:0]               rise_hist_q;
    logic [ODEP-2:0]               fall_hist_q;
    logic [ODEP-1:0]               rise_vec;
    logic [ODEP-1:0]               fall_vec;
    logic [ddrx_pkg::OFFSET_W-1:0] offset_q;
    logic                          rise_evt;
    logic                          fall_evt;
    logic                          armed_q;
    logic [NIN-1:0]                cap_rise_q;
    logic [NIN-1:0]                cap_fall_q;
    logic [NIN-1:0]                rise_rr_q;
    logic [NIN-1:0]                fall_rr_q;
    logic                          pair_q;
    logic                          shift_en_q;
    logic [7:0]                    word_q [NIN];
    logic [7:0]                    word_next [NIN];
    logic [1:0]                    pair_cnt_q;
    logic                          word_done;
    logic [8*LANES-1:0]            wr_word;
    logic [8*LANES-1:0]            wr_data_q;
    logic                          wr_valid_q;
    logic [GROUPS-1:0]             grp_wr_ready;
    logic [GROUPS-1:0]             grp_rd_valid;
    logic                          all_wr_ready;
    logic                          wr_fire;

    // Clock, frame and data share one sampling chain so their skew stays equal
    assign pin_in = {i_forwarded_rx_clock, i_frame, i_data};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A pin level counts only once the second and third stage agree
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lvl_q      <= '0;
            clk_prev_q <= 1'b0;
        end else begin
            lvl_q      <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
            clk_prev_q <= lvl_q[NIN];
        end
    end

    assign rise_raw = lvl_q[NIN] & ~clk_prev_q;
    assign fall_raw = ~lvl_q[NIN] & clk_prev_q;

    // Offset is loaded once after reset and never retuned
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q  <= ddrx_pkg::ST_IDLE;
            offset_q <= ddrx_pkg::OFFSET_RST;
        end else begin
            case (state_q)
                ddrx_pkg::ST_IDLE: begin
                    state_q <= ddrx_pkg::ST_LOAD;
                end
                ddrx_pkg::ST_LOAD: begin
                    offset_q <= i_digital_phase_offset;
                    state_q  <= ddrx_pkg::ST_RUN;
                end
                ddrx_pkg::ST_RUN: begin
                    state_q <= ddrx_pkg::ST_RUN;
                end
                default: begin
                    state_q <= ddrx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign o_phase_locked = (state_q == ddrx_pkg::ST_RUN);

    // Edge-aligned data from the far end; delaying the edge moves the sample mid-eye
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rise_hist_q <= '0;
            fall_hist_q <= '0;
        end else begin
            rise_hist_q <= rise_vec[ODEP-2:0];
            fall_hist_q <= fall_vec[ODEP-2:0];
        end
    end

    assign rise_vec = {rise_hist_q, rise_raw};
    assign fall_vec = {fall_hist_q, fall_raw};
    assign rise_evt = rise_vec[offset_q] & o_phase_locked & armed_q;
    assign fall_evt = fall_vec[offset_q] & o_phase_locked;

    // The forwarded clock may idle high, so filling the sync chain after reset looks
    // like a rise; a pair only counts once a real falling edge has been taken
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed_q <= 1'b0;
        end else if (fall_evt) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_rise_q <= '0;
            cap_fall_q <= '0;
        end else begin
            if (rise_evt) begin
                cap_rise_q <= lvl_q[NIN-1:0];
            end
            if (fall_evt) begin
                cap_fall_q <= lvl_q[NIN-1:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pair_q     <= 1'b0;
            shift_en_q <= 1'b0;
            rise_rr_q  <= '0;
            fall_rr_q  <= '0;
        end else begin
            pair_q     <= rise_evt;
            shift_en_q <= pair_q;
            if (pair_q) begin
                rise_rr_q <= cap_rise_q;
                fall_rr_q <= cap_fall_q;
            end
        end
    end

    // Falling-edge bit is the older of each pair, so it shifts in below the rising one
    for (genvar i = 0; i < NIN; i++) begin : g_lane
        assign word_next[i] = {rise_rr_q[i], fall_rr_q[i], word_q[i][7:2]};
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                word_q[i] <= ddrx_pkg::WORD_RST;
            end else if (shift_en_q) begin
                word_q[i] <= word_next[i];
            end
        end
        if (i < LANES) begin : g_pack
            assign wr_word[8*i +: 8] = word_next[i];
        end
    end

    // Frame high in the first four slots marks a boundary; else count four pairs
    assign word_done = shift_en_q & (i_frame_en ?
                       (word_next[LANES] == ddrx_pkg::FRAME_PATTERN) :
                       (pair_cnt_q == ddrx_pkg::LAST_PAIR));

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pair_cnt_q <= ddrx_pkg::PAIR_CNT_RST;
        end else if (shift_en_q) begin
            pair_cnt_q <= word_done ? ddrx_pkg::PAIR_CNT_RST : pair_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_valid_q <= 1'b0;
            wr_data_q  <= '0;
        end else begin
            wr_valid_q <= word_done;
            if (word_done) begin
                wr_data_q <= wr_word;
            end
        end
    end

    // The link cannot be paused: a word is dropped whole if any group is full
    assign all_wr_ready = &grp_wr_ready;
    assign wr_fire      = wr_valid_q & all_wr_ready;
    assign o_rd_valid   = &grp_rd_valid;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_overrun <= 1'b0;
        end else if (wr_valid_q && !all_wr_ready) begin
            o_overrun <= 1'b1;
        end
    end

    for (genvar g = 0; g < GROUPS; g++) begin : g_group
        ddrx_fifo #(
            .WIDTH (GW),
            .DEPTH (DEPTH)
        ) u_fifo (
            .i_clk           (i_clk),
            .i_rst_b         (i_rst_b),
            .i_wr_valid      (wr_fire),
            .o_wr_ready      (grp_wr_ready[g]),
            .i_wr_data       (wr_data_q[GW*g +: GW]),
            .o_rd_valid      (grp_rd_valid[g]),
            .i_rd_ready      (i_rd_ready & o_rd_valid),
            .o_rd_data       (o_rd_data[GW*g +: GW]),
            .o_quarter       (o_quarter[g]),
            .o_half          (o_half[g]),
            .o_three_quarter (o_three_quarter[g])
        );
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    fall_capture_a: assert property (fall_evt |=> cap_fall_q == $past(lvl_q[NIN-1:0]))
        else $error("falling-edge bit not captured");
    rise_capture_a: assert property (rise_evt |=> cap_rise_q == $past(lvl_q[NIN-1:0]))
        else $error("rising-edge bit not captured");
    rereg_pair_a: assert property (rise_evt |=> pair_q ##1 shift_en_q)
        else $error("captured pair not re-registered and shifted");
    lsb_first_a: assert property (shift_en_q |=>
                                  word_q[0][7:6] == $past({rise_rr_q[0], fall_rr_q[0]}))
        else $error("new bits not entering at the top of the word");
    offset_once_a: assert property (o_phase_locked |=> o_phase_locked && $stable(offset_q))
        else $error("phase offset changed after lock");
    no_early_cap_a: assert property (!o_phase_locked |-> !rise_evt && !fall_evt)
        else $error("capture before phase offset applied");
    frame_align_a: assert property (word_done && i_frame_en |->
                                    word_next[LANES] == ddrx_pkg::FRAME_PATTERN)
        else $error("word boundary not on frame pattern");
    write_qual_a: assert property (word_done |=> wr_valid_q ##1 !wr_valid_q)
        else $error("write qualifier not a single pulse per word");
    write_spacing_a: assert property (wr_valid_q |=> !wr_valid_q [*3])
        else $error("words written too close together");
    overrun_flag_a: assert property (wr_valid_q && !all_wr_ready |=> o_overrun)
        else $error("dropped word not flagged");
    overrun_sticky_a: assert property (o_overrun |=> o_overrun)
        else $error("overrun flag cleared without reset");
    // A one-cycle glitch on a pin must never move the accepted level
    sync_agree_a: assert property (((lvl_q ^ $past(lvl_q)) & $past(s2_q ^ s3_q)) == '0)
        else $error("pin level moved while sync stages disagreed");

    framed_word_c: cover property (word_done && i_frame_en);
    free_word_c: cover property (word_done && !i_frame_en);
    read_word_c: cover property (o_rd_valid && i_rd_ready);
    overrun_c: cover property (wr_valid_q && !all_wr_ready);
endmodule

// ---- tb/ddrx_ser_model.sv ----
// Behavioural model of the far-end DDR serializer: forwarded clock, frame, four lanes.
// Assumes a word handshake from the bench on i_clk; sends LSB first, one fall and one rise bit per pair.
`timescale 1ns/1ps
module ddrx_ser_model #(
    parameter int unsigned HALF = 8
) (
    input  wire logic        i_clk,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_word,
    input  wire logic [2:0]  i_pairs,
    input  wire logic        i_frame_on,
    input  wire logic [7:0]  i_gap,
    output logic             o_ready,
    output logic             o_fwd_clk,
    output logic             o_frame,
    output logic [3:0]       o_data
);
    logic [31:0] word_q;
    logic        fon_q;
    int          slots;
    int          gap;
    initial begin
        o_ready = 1'h1;
        o_fwd_clk = 1'h1;
        o_frame = 1'h0;
        o_data = 4'h0;
        forever begin
            @(posedge i_clk);
            if (i_valid === 1'h1 && o_ready === 1'h1) begin
                word_q = i_word;
                fon_q = i_frame_on;
                slots = 2 * int'(i_pairs);
                gap = int'(i_gap);
                o_ready <= 1'h0;
                for (int s = 0; s < slots; s++) begin
                    // Data launched on the clock edge itself; receiver must centre
                    o_fwd_clk <= s[0];
                    for (int n = 0; n < 4; n++) begin
                        o_data[n] <= word_q[8*n+s];
                    end
                    o_frame <= fon_q && (s < 4);
                    repeat (HALF) @(posedge i_clk);
                end
                // Hold time over: lines no longer show the last bit
                o_data <= ~o_data;
                o_frame <= ~o_frame;
                repeat (gap) @(posedge i_clk);
                o_ready <= 1'h1;
            end
        end
    end
endmodule

// ---- tb/ddrx_rx_top_test.sv ----
// Self-checking bench for the DDR 1:8 receiver with four lanes and one word buffer.
// Assumes the serializer model drives all pins; the bench owns reset, straps and the read side.
`timescale 1ns/1ps
module ddrx_rx_top_test;
    localparam int unsigned HALF  = 8;
    localparam int unsigned DEPTH = 32;
    localparam int unsigned LIMIT = 20000;
    logic        i_clk = 1'h0;
    logic        i_rst_b = 1'h0;
    logic        i_frame_en = 1'h1;
    logic [2:0]  i_digital_phase_offset = 3'h0;
    logic        i_rd_ready = 1'h0;
    logic        fwd_clk;
    logic        frame;
    logic [3:0]  data;
    logic [31:0] o_rd_data;
    logic        o_rd_valid;
    logic        o_quarter;
    logic        o_half;
    logic        o_three_quarter;
    logic        o_overrun;
    logic        o_phase_locked;
    logic        m_valid = 1'h0;
    logic        m_ready;
    logic [31:0] m_word = 32'h0000_0000;
    logic [2:0]  m_pairs = 3'h4;
    logic        m_frame_on = 1'h1;
    logic [7:0]  m_gap = 8'h00;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [31:0] exp_q[$];

    always #12.5 i_clk = ~i_clk;

    ddrx_rx_top #(.LANES(4), .DEPTH(DEPTH)) u_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_forwarded_rx_clock(fwd_clk), .i_frame(frame),
        .i_data(data), .i_frame_en(i_frame_en), .i_digital_phase_offset(i_digital_phase_offset),
        .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_quarter(o_quarter), .o_half(o_half), .o_three_quarter(o_three_quarter),
        .o_overrun(o_overrun), .o_phase_locked(o_phase_locked));

    ddrx_ser_model #(.HALF(HALF)) u_far (
        .i_clk(i_clk), .i_valid(m_valid), .i_word(m_word), .i_pairs(m_pairs),
        .i_frame_on(m_frame_on), .i_gap(m_gap), .o_ready(m_ready), .o_fwd_clk(fwd_clk),
        .o_frame(frame), .o_data(data));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apply_reset(input logic [2:0] offset, input logic fen);
        @(posedge i_clk);
        i_rst_b <= 1'h0;
        i_digital_phase_offset <= offset;
        i_frame_en <= fen;
        repeat (5) @(negedge i_clk);
        check({o_rd_valid, o_quarter, o_half, o_three_quarter, o_overrun, o_phase_locked}, 0);
        @(posedge i_clk);
        i_rst_b <= 1'h1;
        repeat (4) @(negedge i_clk);
        check(o_phase_locked, 1);
    endtask

    // Holds the request until the model's ready is sampled high
    task automatic send(input logic [31:0] w, input logic [2:0] pairs, input logic fon,
                        input logic [7:0] gap);
        @(posedge i_clk);
        m_valid <= 1'h1;
        m_word <= w;
        m_pairs <= pairs;
        m_frame_on <= fon;
        m_gap <= gap;
        @(posedge i_clk);
        while (m_ready !== 1'h1) @(posedge i_clk);
        m_valid <= 1'h0;
        if (pairs == 3'h4) exp_q.push_back(w);
    endtask

    task automatic pop_check();
        int w;
        w = 0;
        @(negedge i_clk);
        while (o_rd_valid !== 1'h1 && w < 400) begin
            @(negedge i_clk);
            w++;
        end
        check(o_rd_valid, 1);
        check(o_rd_data, exp_q.pop_front());
        @(posedge i_clk);
        i_rd_ready <= 1'h1;
        @(posedge i_clk);
        i_rd_ready <= 1'h0;
    endtask

    task automatic expect_empty();
        repeat (12) @(negedge i_clk);
        check({o_rd_valid, o_quarter, o_half, o_three_quarter}, 0);
    endtask

    // Half a word of junk first: only the frame can put the boundary right
    task automatic t_framed();
        send(32'hFFFF_FFFF, 3'h2, 1'h0, 8'h00);
        send(32'h8421_1248, 3'h4, 1'h1, 8'h00);
        send(32'hA5C3_0FF0, 3'h4, 1'h1, 8'h00);
        send(32'h0001_8000, 3'h4, 1'h1, 8'h00);
        repeat (3) pop_check();
        expect_empty();
    endtask

    task automatic t_free();
        send(32'h3C96_E187, 3'h4, 1'h0, 8'h14);
        send(32'h7E01_80FE, 3'h4, 1'h0, 8'h14);
        repeat (2) pop_check();
        expect_empty();
    endtask

    // Slow partner: one word at a time, flags judged after each write
    task automatic t_fill();
        logic [31:0] w;
        for (int k = 1; k <= DEPTH + 1; k++) begin
            w = {8'h5A, 8'(k), ~8'(k), 8'(3 * k)};
            send(w, 3'h4, 1'h1, 8'h00);
            if (k > DEPTH) void'(exp_q.pop_back());
            repeat (8 * HALF + 16) @(posedge i_clk);
            @(negedge i_clk);
            check(o_quarter, (k >= DEPTH / 4));
            check(o_half, (k >= DEPTH / 2));
            check(o_three_quarter, (k >= 3 * DEPTH / 4));
        end
        check(o_overrun, 1);
        repeat (DEPTH) pop_check();
        expect_empty();
        check(o_overrun, 1);
    endtask

    task automatic t_offset();
        apply_reset(3'h3, 1'h1);
        check(o_overrun, 0);
        send(32'hF00F_1EE1, 3'h4, 1'h1, 8'h00);
        send(32'h0BAD_F00D, 3'h4, 1'h1, 8'h00);
        repeat (2) pop_check();
        expect_empty();
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        apply_reset(3'h0, 1'h1);
        t_framed();
        apply_reset(3'h0, 1'h0);
        t_free();
        apply_reset(3'h0, 1'h1);
        t_fill();
        t_offset();
        test_done();
    end
endmodule
